// *** src/qrp_top.sv ***
// quick request path: five parameter registers plus submitting aliases, per-priority
// request queues, one address generator serving the queue heads lowest index first, and event channel gating.
// assumes a single 10 MHz sys_clk, axi4-lite slave, synchronous event inputs.
//
// Contract
// - three plain writes, alias write submits
// - each register write takes one cycle, except an alias write whose queue is full
// - element tally is 16 bits wide
// - update mode 01b increments per element
// - priority in option bits 31:29
// - completion code upper bits reserved option
// - 2-D block sync covers whole sub-block
// - array index is gap between arrays
// - source and destination share the array gap in index bits 31:16
// - later submissions wait in queues
// - any of five registers may submit
// - completion signalled when irq enable set
// - each event owns an independent channel
// - channel responds to its event only when enabled; a cpu set fires it regardless
// - one or many elements per event
// - quick requests always frame synchronized
// - one request per queue head served
`timescale 1ns/1ns
module qrp_top #(
  parameter int NQ        = 4,
  parameter int QDEPTH    = 4,
  parameter int NCH       = 8,
  parameter int BURST     = 4,
  parameter bit EXT_TCC   = 1'b1
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [NCH-1:0] sync_event,
  output logic [NCH-1:0]   chan_fire,
  input  wire logic        elem_ack,
  output logic             elem_req,
  output logic [31:0]      elem_src_addr,
  output logic [31:0]      elem_dst_addr,
  output logic [1:0]       elem_queue,
  output logic             completion_pulse,
  output logic [3:0]       completion_code
);
  localparam int QW = $clog2(QDEPTH);
  localparam int QS = $clog2(NQ);
  // byte span of the five parameter words; anything above it in the low page is unmapped
  localparam logic [7:0] PRM_SPAN = 8'(4 * qrp_pkg::NUM_PARAMS);

  // parameter registers: opt, src, cnt, dst, idx
  logic [31:0] prm [qrp_pkg::NUM_PARAMS];
  logic [31:0] event_enable_reg;
  logic [31:0] chain_event_enable_reg;
  logic [31:0] done_flags;

  // write channel capture: address and data may arrive in any order
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  wire        wr_go     = aw_held && w_held && !s_axi_bvalid;
  wire [7:0]  wr_off    = {aw_addr[7:2], 2'b00};
  wire        wr_plain  = wr_go && wr_off < PRM_SPAN;
  wire        wr_alias  = wr_go && wr_off >= qrp_pkg::OFS_ALIAS
                          && wr_off < 8'(qrp_pkg::OFS_ALIAS + PRM_SPAN);
  wire [2:0]  wr_idx    = wr_off[4:2];
  wire        wr_known  = wr_plain || wr_alias || wr_off == qrp_pkg::OFS_EVT_EN
                          || wr_off == qrp_pkg::OFS_CHAIN_EN
                          || wr_off == qrp_pkg::OFS_EVT_SET || wr_off == qrp_pkg::OFS_DONE;

  // merged view of the parameter words after this write (alias uses written value)
  logic [31:0] wmask;
  always_comb begin
    for (int b = 0; b < 4; b++) wmask[b*8 +: 8] = {8{w_strb[b]}};
  end
  wire [31:0] merged = (prm[wr_idx] & ~wmask) | (w_data & wmask);
  wire [31:0] sub_opt = (wr_idx == 3'd0) ? merged : prm[0];
  wire [31:0] sub_src = (wr_idx == 3'd1) ? merged : prm[1];
  wire [31:0] sub_cnt = (wr_idx == 3'd2) ? merged : prm[2];
  wire [31:0] sub_dst = (wr_idx == 3'd3) ? merged : prm[3];
  wire [31:0] sub_idx = (wr_idx == 3'd4) ? merged : prm[4];
  wire [2:0]  sub_pri = sub_opt[qrp_pkg::PRI_HI:qrp_pkg::PRI_LO];
  wire [QS-1:0] sub_q = QS'(sub_pri);
  // upper completion code masked when that space is absent
  wire [1:0]  completion_code_upper    = EXT_TCC ? sub_opt[qrp_pkg::COMPLETION_CODE_UPPER_HI:qrp_pkg::COMPLETION_CODE_UPPER_LO] : 2'b00;

  // queue storage: entry = opt, src, cnt, dst, idx
  logic [159:0] qmem [NQ][QDEPTH];
  logic [QW:0]  qwp [NQ];
  logic [QW:0]  qrp [NQ];
  logic [NQ-1:0] qfull;
  logic [NQ-1:0] qempty;
  logic [NQ-1:0] qpop;

  // full target queue stalls the alias write
  wire stall   = wr_alias && qfull[sub_q];
  wire wr_do   = wr_go && !stall;
  wire push    = wr_alias && !stall;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  // axi write path and parameter registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= qrp_pkg::RST_WORD;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= qrp_pkg::RESP_OK;
      for (int i = 0; i < qrp_pkg::NUM_PARAMS; i++) prm[i] <= qrp_pkg::RST_WORD;
      event_enable_reg       <= qrp_pkg::RST_WORD;
      chain_event_enable_reg <= qrp_pkg::RST_WORD;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (wr_do) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? qrp_pkg::RESP_OK : qrp_pkg::RESP_ERR;
        // plain and alias writes both store; values persist
        if (wr_plain || wr_alias) prm[wr_idx] <= merged;
        if (wr_off == qrp_pkg::OFS_EVT_EN) event_enable_reg <= w_data;
        if (wr_off == qrp_pkg::OFS_CHAIN_EN) chain_event_enable_reg <= w_data;
      end
    end
  end

  // pushes queue behind older requests; sync bit forced to frame
  genvar gq;
  generate
    for (gq = 0; gq < NQ; gq++) begin : g_q
      assign qfull[gq]  = (qwp[gq][QW] != qrp[gq][QW]) && (qwp[gq][QW-1:0] == qrp[gq][QW-1:0]);
      assign qempty[gq] = qwp[gq] == qrp[gq];
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          qwp[gq] <= '0;
          qrp[gq] <= '0;
        end else begin
          if (push && sub_q == QS'(gq)) begin
            qmem[gq][qwp[gq][QW-1:0]] <= {sub_opt[31:15], completion_code_upper, sub_opt[12:1], 1'b1,
                                          sub_src, sub_cnt, sub_dst, sub_idx};
            qwp[gq] <= qwp[gq] + 1'b1;
          end
          if (qpop[gq]) qrp[gq] <= qrp[gq] + 1'b1;
        end
      end
    end
  endgenerate

  // address generator: serves one queue head at a time, lowest index first
  logic          busy;
  logic [QS-1:0] cur_q;
  logic [31:0]   cur_opt;
  logic [31:0]   cur_src;
  logic [31:0]   cur_dst;
  logic [31:0]   cur_idx;
  logic [31:0]   src_line;
  logic [31:0]   dst_line;
  logic [qrp_pkg::TALLY_W-1:0] elem_left;
  logic [qrp_pkg::TALLY_W-1:0] elem_tot;
  logic [15:0]   arr_left;
  logic [QS-1:0] pick;
  logic          any_ready;
  always_comb begin
    pick = '0;
    any_ready = 1'b0;
    for (int i = NQ - 1; i >= 0; i--) begin
      if (!qempty[i]) begin
        pick = QS'(i);
        any_ready = 1'b1;
      end
    end
  end
  wire [159:0] head = qmem[pick][qrp[pick][QW-1:0]];
  always_comb begin
    qpop = '0;
    if (!busy && any_ready) qpop[pick] = 1'b1;
  end
  wire step     = busy && elem_req && elem_ack;
  wire last_el  = elem_left == 16'd1;
  wire last_arr = arr_left == 16'd0;
  wire [1:0] sum = cur_opt[qrp_pkg::SUM_HI:qrp_pkg::SUM_LO];
  wire [1:0] dst_addr_update_mode = cur_opt[qrp_pkg::DUM_HI:qrp_pkg::DUM_LO];
  wire [31:0] esz = 32'd4;
  // increment mode advances by one element; array gap added at line end
  wire [31:0] nsrc_el = (sum == qrp_pkg::UPD_INC) ? cur_src + esz : cur_src;
  wire [31:0] ndst_el = (dst_addr_update_mode == qrp_pkg::UPD_INC) ? cur_dst + esz : cur_dst;
  wire [31:0] nsrc_ar = nsrc_el + {16'h0000, cur_idx[31:16]};
  wire [31:0] ndst_ar = ndst_el + {16'h0000, cur_idx[31:16]};

  assign elem_req      = busy;
  assign elem_src_addr = cur_src;
  assign elem_dst_addr = cur_dst;
  assign elem_queue    = 2'(cur_q);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      cur_q <= '0;
      cur_opt <= qrp_pkg::RST_WORD;
      cur_src <= qrp_pkg::RST_WORD;
      cur_dst <= qrp_pkg::RST_WORD;
      cur_idx <= qrp_pkg::RST_WORD;
      src_line <= qrp_pkg::RST_WORD;
      dst_line <= qrp_pkg::RST_WORD;
      elem_left <= '0;
      elem_tot <= '0;
      arr_left <= '0;
      completion_pulse <= 1'b0;
      completion_code <= 4'h0;
      done_flags <= qrp_pkg::RST_WORD;
    end else begin
      completion_pulse <= 1'b0;
      if (wr_do && wr_off == qrp_pkg::OFS_DONE) done_flags <= done_flags & ~w_data;
      if (!busy && any_ready) begin
        busy <= 1'b1;
        cur_q <= pick;
        cur_opt <= head[159:128];
        cur_src <= head[127:96];
        // low 16 bits are element tally, upper are array tally
        elem_left <= head[79:64];
        elem_tot  <= head[79:64];
        arr_left  <= head[95:80];
        cur_dst <= head[63:32];
        cur_idx <= head[31:0];
      end else if (step) begin
        // the whole multi-array block runs from one request; too
        if (!last_el) begin
          elem_left <= elem_left - 1'b1;
          cur_src <= nsrc_el;
          cur_dst <= ndst_el;
        end else if (!last_arr) begin
          elem_left <= elem_tot;
          arr_left <= arr_left - 1'b1;
          cur_src <= nsrc_ar;
          cur_dst <= ndst_ar;
        end else begin
          busy <= 1'b0;
          // completion reported only with irq enable
          if (cur_opt[qrp_pkg::COMPLETION_IRQ_ENABLE_B]) begin
            completion_pulse <= 1'b1;
            completion_code <= cur_opt[qrp_pkg::TCC_HI:qrp_pkg::TCC_LO];
            done_flags[cur_opt[qrp_pkg::TCC_HI:qrp_pkg::TCC_LO]] <= 1'b1;
          end
        end
      end
    end
  end

  // one independent channel per event; gated by enables
  logic [NCH-1:0] cpu_sync;
  assign cpu_sync = (wr_do && wr_off == qrp_pkg::OFS_EVT_SET) ? w_data[NCH-1:0] : '0;
  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc++) begin : g_ch
      logic [$clog2(BURST+1)-1:0] left;
      wire en  = event_enable_reg[gc] | chain_event_enable_reg[gc];
      wire trg = (sync_event[gc] && en) || cpu_sync[gc];
      // one element per event or a burst of BURST
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) left <= '0;
        else if (trg) left <= event_enable_reg[gc+NCH] ? ($bits(left))'(BURST) : ($bits(left))'(1);
        else if (left != 0) left <= left - 1'b1;
      end
      assign chan_fire[gc] = left != 0;
    end
  endgenerate

  // read path
  logic [31:0] rd_mux;
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  always_comb begin
    rd_mux = qrp_pkg::RST_WORD;
    if (ra < PRM_SPAN) rd_mux = prm[ra[4:2]];
    else if (ra == qrp_pkg::OFS_EVT_EN) rd_mux = event_enable_reg;
    else if (ra == qrp_pkg::OFS_CHAIN_EN) rd_mux = chain_event_enable_reg;
    else if (ra == qrp_pkg::OFS_DONE) rd_mux = done_flags;
    else if (ra == qrp_pkg::OFS_QSTAT) rd_mux = {24'h0, 3'h0, busy, NQ'(qempty)};
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= qrp_pkg::RST_WORD;
      s_axi_rresp  <= qrp_pkg::RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= qrp_pkg::RESP_OK;
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end

  // checks
  a_alias_push: assert property (@(posedge sys_clk) disable iff (!rst_b)
    push |=> !qempty[$past(sub_q)]) else $error("alias write did not queue");
  a_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_go && !wr_alias) |=> s_axi_bvalid) else $error("write not done in one cycle");
  a_stall_full: assert property (@(posedge sys_clk) disable iff (!rst_b)
    stall |=> !s_axi_bvalid || $past(s_axi_bvalid)) else $error("full queue write answered");
  a_keep_parameter_ram: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !wr_do |=> $stable(prm[1])) else $error("parameter_ram changed without write");
  a_one_head: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $onehot0(qpop) && !(busy && qpop != '0)) else $error("two heads served");
  a_inc_src: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (step && !last_el && sum == qrp_pkg::UPD_INC) |=> cur_src == $past(cur_src) + 32'd4)
    else $error("source did not increment");
  a_done_irq: assert property (@(posedge sys_clk) disable iff (!rst_b)
    completion_pulse |-> $past(cur_opt[qrp_pkg::COMPLETION_IRQ_ENABLE_B])) else $error("spurious completion");
  a_chan_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (sync_event[0] && !event_enable_reg[0] && !chain_event_enable_reg[0] && !cpu_sync[0]
     && !chan_fire[0]) |=> !chan_fire[0]) else $error("disabled channel fired");
  c_submit: cover property (@(posedge sys_clk) push);
  c_stall:  cover property (@(posedge sys_clk) stall);
  c_done:   cover property (@(posedge sys_clk) completion_pulse);
endmodule : qrp_top

// *** src/qrp_pkg.sv ***
// package for the quick request path: register map, option fields, queue and event constants
// assumes a 32-bit axi4-lite slave port and a 10 MHz sys_clk
package qrp_pkg;
  // register byte addresses: parameter set, submitting aliases, then event, done and queue status registers
  localparam logic [7:0] OFS_OPT       = 8'h00;
  localparam logic [7:0] OFS_SRC       = 8'h04;
  localparam logic [7:0] OFS_CNT       = 8'h08;
  localparam logic [7:0] OFS_DST       = 8'h0c;
  localparam logic [7:0] OFS_IDX       = 8'h10;
  localparam logic [7:0] OFS_ALIAS     = 8'h20;
  localparam logic [7:0] OFS_EVT_EN    = 8'h40;
  localparam logic [7:0] OFS_CHAIN_EN  = 8'h44;
  localparam logic [7:0] OFS_EVT_SET   = 8'h48;
  localparam logic [7:0] OFS_DONE      = 8'h4c;
  localparam logic [7:0] OFS_QSTAT     = 8'h50;
  localparam int         NUM_PARAMS    = 5;
  // option field positions
  localparam int PRI_HI  = 31;
  localparam int PRI_LO  = 29;
  localparam int SUM_HI  = 26;
  localparam int SUM_LO  = 25;
  localparam int DUM_HI  = 22;
  localparam int DUM_LO  = 21;
  localparam int COMPLETION_IRQ_ENABLE_B = 20;
  localparam int TCC_HI  = 19;
  localparam int TCC_LO  = 16;
  localparam int COMPLETION_CODE_UPPER_HI = 14;
  localparam int COMPLETION_CODE_UPPER_LO = 13;
  localparam int SYNC_B  = 0;
  // address update modes and priority codes
  localparam logic [1:0] UPD_FIXED = 2'h0;
  localparam logic [1:0] UPD_INC   = 2'h1;
  localparam logic [2:0] PRI_LOW_A = 3'h2;
  localparam logic [2:0] PRI_LOW_B = 3'h3;
  // element tally width
  localparam int TALLY_W = 16;
  // reset values and write response codes
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
endpackage : qrp_pkg

// *** verif/qrp_mover_model.sv ***
// element mover model: acknowledges element requests from the address generator
// assumes elem_req is a level held until the last element is acknowledged
`timescale 1ns/1ns
module qrp_mover_model (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic slow,
  input  wire logic elem_req,
  output logic      elem_ack
);
  logic [1:0] gap_cnt;
  // slow mode acks in one cycle of three, as a busy port would
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_cnt  <= 2'h0;
      elem_ack <= 1'b0;
    end else begin
      gap_cnt  <= (gap_cnt == 2'h2) ? 2'h0 : gap_cnt + 2'h1;
      elem_ack <= elem_req && (!slow || gap_cnt == 2'h2);
    end
  end
endmodule : qrp_mover_model

// *** verif/qrp_tb_top.sv ***
// testbench for the quick request path: axi4-lite tasks, element log, event checks
// assumes the mover model on the element side and default queue sizes
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module quick_transfer_request_path_tb_top;
  localparam int NCH = 8;
  localparam int TB_BURST = 4;
  logic           sys_clk, rst_b, slow, elem_ack, elem_req, cpl;
  logic [7:0]     awaddr, araddr;
  logic           awvalid, wvalid, bready, arvalid, rready;
  logic           awready, wready, bvalid, arready, rvalid;
  logic [31:0]    wdata, rdata, elem_src, elem_dst, rd_data;
  logic [1:0]     bresp, rresp, elem_q, q_last, wr_resp;
  logic [3:0]     cpl_code;
  logic [NCH-1:0] sync_ev, chan_fire;
  logic [31:0]    src_log[$];
  logic [31:0]    dst_log[$];
  int             n_done, wr_lat, error_cnt, n_tests, fire_cnt[NCH];

  qrp_top #(.NCH(NCH), .BURST(TB_BURST)) dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sync_event(sync_ev), .chan_fire(chan_fire), .elem_ack(elem_ack), .elem_req(elem_req),
    .elem_src_addr(elem_src), .elem_dst_addr(elem_dst), .elem_queue(elem_q),
    .completion_pulse(cpl), .completion_code(cpl_code));
  qrp_mover_model mover_u (.sys_clk(sys_clk), .rst_b(rst_b), .slow(slow),
    .elem_req(elem_req), .elem_ack(elem_ack));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // log each element moved, each completion and each busy channel cycle
  always @(posedge sys_clk) begin
    if (elem_req === 1'b1 && elem_ack === 1'b1) begin
      src_log.push_back(elem_src);
      dst_log.push_back(elem_dst);
      q_last = elem_q;
    end
    if (cpl === 1'b1)
      n_done++;
    for (int c = 0; c < NCH; c++)
      fire_cnt[c] += int'(chan_fire[c] === 1'b1);
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (wr_lat = 1; wr_lat <= 300; wr_lat++) begin
      @(posedge sys_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (wr_lat > 300) begin
      error_cnt++;
      finish_test();
    end
    wr_resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (k = 1; k <= 300; k++) begin
      @(posedge sys_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (k > 300) begin
      error_cnt++;
      finish_test();
    end
    rd_data = rdata;
    rready <= 1'b0;
  endtask : rd

  // bounded wait for a number of completions in total
  task automatic wait_done(input int n);
    int k;
    for (k = 0; k < 3000 && n_done < n; k++)
      @(posedge sys_clk);
    if (n_done < n) begin
      error_cnt++;
      finish_test();
    end
  endtask : wait_done

  function automatic logic [31:0] mk_opt(input logic [1:0] sm, input logic [1:0] dm,
                                         input logic [3:0] code);
    logic [31:0] o;
    o = 32'h0;
    o[qrp_pkg::PRI_HI:qrp_pkg::PRI_LO] = qrp_pkg::PRI_LOW_A;
    o[qrp_pkg::SUM_HI:qrp_pkg::SUM_LO] = sm;
    o[qrp_pkg::DUM_HI:qrp_pkg::DUM_LO] = dm;
    o[qrp_pkg::COMPLETION_IRQ_ENABLE_B] = 1'b1;
    o[qrp_pkg::TCC_HI:qrp_pkg::TCC_LO] = code;
    return o;
  endfunction : mk_opt

  initial begin
    {rst_b, slow, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, sync_ev} = '0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    // unmapped places and reset value
    rd(qrp_pkg::OFS_SRC);
    `CHK("src_reset", qrp_pkg::RST_WORD, rd_data)
    wr(8'hf0, 32'h1);
    `CHK("unmapped_wr", qrp_pkg::RESP_ERR, wr_resp)
    rd(8'hf0);
    `CHK("unmapped_rd", 32'h0, rd_data)
    // three plain writes, then the options alias submits
    wr(qrp_pkg::OFS_SRC, 32'h1000);
    wr(qrp_pkg::OFS_DST, 32'h2000);
    wr(qrp_pkg::OFS_CNT, 32'h3);
    `CHK("wr_latency", 3, wr_lat)
    repeat (4) @(posedge sys_clk);
    `CHK("no_early_start", 0, src_log.size())
    wr(qrp_pkg::OFS_ALIAS + qrp_pkg::OFS_OPT, mk_opt(qrp_pkg::UPD_INC, qrp_pkg::UPD_FIXED, 4'h5));
    wait_done(1);
    `CHK("a_count", 3, src_log.size())
    for (int i = 0; i < 3; i++) begin
      `CHK("a_src", 32'h1000 + 4 * i, src_log[i])
      `CHK("a_dst", 32'h2000, dst_log[i])
    end
    `CHK("a_queue", qrp_pkg::PRI_LOW_A[1:0], q_last)
    `CHK("a_code", 4'h5, cpl_code)
    rd(qrp_pkg::OFS_SRC);
    `CHK("src_kept", 32'h1000, rd_data)
    $display("test block move done");
    // 2-D request submitted by the index alias, then a second one at once
    slow <= 1'b1;
    wr(qrp_pkg::OFS_OPT, mk_opt(qrp_pkg::UPD_INC, qrp_pkg::UPD_INC, 4'h9));
    wr(qrp_pkg::OFS_SRC, 32'h3000);
    wr(qrp_pkg::OFS_DST, 32'h4000);
    wr(qrp_pkg::OFS_CNT, 32'h0001_0002);
    wr(qrp_pkg::OFS_ALIAS + qrp_pkg::OFS_IDX, 32'h0010_0000);
    wr(qrp_pkg::OFS_SRC, 32'h5000);
    wr(qrp_pkg::OFS_ALIAS + qrp_pkg::OFS_DST, 32'h6000);
    wait_done(3);
    `CHK("b_count", 11, src_log.size())
    for (int j = 0; j < 8; j++)
      `CHK("b_src", (j < 4 ? 32'h3000 : 32'h5000) + (j % 2) * 4 + ((j / 2) % 2) * 24,
           src_log[3 + j])
    `CHK("b_code", 4'h9, cpl_code)
    $display("test sub-block and queueing done");
    // completion flags: both codes set, then writing a one clears code 5
    rd(qrp_pkg::OFS_DONE);
    `CHK("done_flags", 32'h0000_0220, rd_data)
    wr(qrp_pkg::OFS_DONE, 32'h0000_0020);
    rd(qrp_pkg::OFS_DONE);
    `CHK("done_clear", 32'h0000_0200, rd_data)
    // full queue: a long request holds the generator, so the sixth alias write must wait
    wr(qrp_pkg::OFS_CNT, 32'h0000_0020);
    for (int s = 0; s < 6; s++)
      wr(qrp_pkg::OFS_ALIAS + qrp_pkg::OFS_SRC, 32'h7000);
    `CHK("stall_wait", 1'b1, wr_lat > 3)
    wait_done(9);
    `CHK("stall_count", 203, src_log.size())
    $display("test completion flags and full queue done");
    // events: none enabled, then single, burst and chained channels
    @(posedge sys_clk);
    sync_ev <= '1;
    @(posedge sys_clk);
    sync_ev <= '0;
    repeat (10) @(posedge sys_clk);
    `CHK("fire_disabled", 0, fire_cnt[1] + fire_cnt[2] + fire_cnt[3])
    wr(qrp_pkg::OFS_EVT_EN, 32'h6 | (32'h4 << NCH));
    wr(qrp_pkg::OFS_CHAIN_EN, 32'h8);
    @(negedge sys_clk);
    foreach (fire_cnt[c]) fire_cnt[c] = 0;
    @(posedge sys_clk);
    sync_ev <= '1;
    @(posedge sys_clk);
    sync_ev <= '0;
    repeat (12) @(posedge sys_clk);
    `CHK("fire_single", 1, fire_cnt[1])
    `CHK("fire_burst", TB_BURST, fire_cnt[2])
    `CHK("fire_chained", 1, fire_cnt[3])
    `CHK("fire_off", 0, fire_cnt[0])
    wr(qrp_pkg::OFS_EVT_SET, 32'h1);
    repeat (6) @(posedge sys_clk);
    `CHK("fire_cpu_set", 1, fire_cnt[0])
    $display("test event channels done");
    finish_test();
  end
endmodule : quick_transfer_request_path_tb_top
